// >>> core/swc_sleep_wake_watchdog_control.sv
// Sleep and wake sequencer, sleep timer, watchdog and reset trip configuration.
`timescale 1ns/1ns
// Operation
// - Clearing power-on flag arms watchdog permanently.
// - Only power-on reset disarms the watchdog.
// - Low-power clocked sleep timer interrupts on overflow.
// - Third overflow without clear fires watchdog reset.
// - Clear write zeros watchdog; 0x38 also timer.
// - Sleep bit halts CPU until interrupt or reset.
// - Any unmasked interrupt wakes unless the stop bit is set, ignoring global enable.
// - Oscillator gets three low-power periods to recover.
// - Next instruction runs before interrupt service.
// - Sleep write raises halt request immediately.
// - CPU acknowledges halt at next rising edge.
// - After acknowledge, power down at CPU falling edge.
// - Power-down switches flash, oscillator, filter, bandgap off.
// - Wake interrupt captured on low-power falling edge.
// - Next low-power rising edge ends power-down.
// - Following rising edge samples precision reset comparator.
// - First low-power falling edge after oscillator recovery drops halt request.
// - Trip field selects reset threshold or monitor-only.
// - Power-on sets flag; no watchdog reset meanwhile.
// - Watchdog reset sets flag; software clears only.
module swc_sleep_wake_watchdog_control
  import swc_pkg::*;
(
  input  wire logic                       clk,                     // System clock, 250 MHz.
  input  wire logic                       nrst,                    // Power-on reset, active low.
  input  wire swc_pkg::swc_io_req_type    io_req,                  // CPU I/O bus request.
  output logic                      [7:0] io_rdata,                // Read data, valid after a read.
  input  wire logic                       lp_clk_in,               // Low-power 32 kHz clock.
  input  wire logic                       processor_clock,         // CPU clock.
  input  wire logic                       halt_acknowledge,        // Halt acknowledge from the CPU.
  input  wire logic                 [7:0] irq_pending,             // Pending interrupt sources.
  input  wire logic                 [7:0] irq_mask,                // Interrupt mask, one enables.
  input  wire logic                       gie,                     // Global interrupt enable flag.
  input  wire logic                       instr_retired,           // Level toggled per retired instruction.
  input  wire logic                       precision_reset_detector_comparator,         // Precision reset comparator output.
  input  wire logic                 [1:0] sleep_interval_sel,      // Sleep period select.
  output logic                            halt_request,            // Halt request to the CPU.
  output logic                            power_down,              // Chip-wide power-down.
  output swc_pkg::swc_power_ctl_type      power_ctl,               // Switched circuit enables.
  output logic                            osc_ready,               // Internal oscillator usable.
  output logic                            watchdog_reset_event,    // One-cycle watchdog reset pulse.
  output logic                            sleep_timer_irq,         // One-cycle sleep timer interrupt.
  output logic                            isr_defer,               // Hold interrupt entry.
  output logic                            cpu_stop,                // CPU stopped by the stop bit.
  output logic                      [1:0] reset_trip_level,        // Threshold to the reset detector.
  output logic                            precision_reset_request  // Reset from the sampled comparator.
);

  // Synchroniser bundle order.
  localparam int SY_LP   = 0;
  localparam int SY_CPU  = 1;
  localparam int SY_ACK  = 2;
  localparam int SY_WAKE = 3;
  localparam int SY_RET  = 4;
  localparam int SY_PRECISION_RESET_DETECTOR = 5;
  localparam int SY_W    = 6;

  swc_state_type state_reg;
  swc_state_type state_next;
  logic [SY_W-1:0] sy_in;
  logic [SY_W-1:0] sy_lvl;
  logic [SY_W-1:0] sy_rise;
  logic [SY_W-1:0] sy_fall;
  logic        wr_scr;
  logic        wr_clr;
  logic        wr_trip;
  logic        sleep_set_wr;
  logic        power_on_flag_reg;
  logic        watchdog_reset_flag_reg;
  logic        sleep_reg;
  logic        stop_reg;
  logic        wdt_en_reg;
  logic [1:0]  wdt_cnt_reg;
  logic [1:0]  wdt_cnt_next;
  logic [14:0] st_cnt_reg;
  logic        st_ovf;
  logic        wdr_now;
  logic        wdr_reg;
  logic        st_irq_reg;
  logic        pd_reg;
  logic [1:0]  rec_cnt_reg;
  logic        osc_ready_reg;
  logic        defer_reg;
  logic [1:0]  trip_reg;
  logic        precision_reset_detector_sample_reg;
  logic        wake_ok;
  logic [7:0]  rdata_reg;

  // Input synchronisers; a wake needs any unmasked pending source, gie is ignored.
  assign sy_in[SY_LP]   = lp_clk_in;
  assign sy_in[SY_CPU]  = processor_clock;
  assign sy_in[SY_ACK]  = halt_acknowledge;
  assign sy_in[SY_WAKE] = |(irq_pending & irq_mask);
  assign sy_in[SY_RET]  = instr_retired;
  assign sy_in[SY_PRECISION_RESET_DETECTOR] = precision_reset_detector_comparator;

  swc_sync #(
    .W (SY_W)
  ) u_sync (
    .clk   (clk),
    .nrst  (nrst),
    .din   (sy_in),
    .level (sy_lvl),
    .rise  (sy_rise),
    .fall  (sy_fall)
  );

  // Address decode; the trip register lives in bank two.
  assign wr_scr  = io_req.wr && (io_req.addr == SWC_ADDR_SCR);
  assign wr_clr  = io_req.wr && (io_req.addr == SWC_ADDR_WDT_CLEAR);
  assign wr_trip = io_req.wr && (io_req.addr == SWC_ADDR_TRIP);
  assign sleep_set_wr = wr_scr && io_req.wdata[SWC_SCR_SLEEP];

  // Sleep timer overflow on the last low-power rising edge of the period.
  assign st_ovf = sy_rise[SY_LP] && (st_cnt_reg == SWC_SLEEP_TERM[sleep_interval_sel]);

  // Watchdog count; a clear write zeroes it but a coincident overflow still counts.
  always_comb begin
    wdt_cnt_next = wdt_cnt_reg;
    if (wr_clr) begin
      wdt_cnt_next = '0;
    end
    if (st_ovf) begin
      wdt_cnt_next = wdt_cnt_next + 2'h1;
    end
  end

  // Reset fires when the count reaches the limit while armed.
  assign wdr_now = wdt_en_reg && !power_on_flag_reg && st_ovf && (wdt_cnt_next == SWC_WDT_LIMIT);

  // Sleep timer counter; a 0x38 clear write restarts it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_cnt_reg <= '0;
      st_irq_reg <= 1'b0;
    end else begin
      st_irq_reg <= st_ovf;
      if (wdr_now || (wr_clr && io_req.wdata == SWC_CLEAR_BOTH)) begin
        st_cnt_reg <= '0;
      end else if (st_ovf) begin
        st_cnt_reg <= '0;
      end else if (sy_rise[SY_LP]) begin
        st_cnt_reg <= st_cnt_reg + 15'h0001;
      end
    end
  end

  // Watchdog counter and reset pulse.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdt_cnt_reg <= '0;
      wdr_reg     <= 1'b0;
    end else begin
      wdr_reg <= wdr_now;
      if (wdr_now) begin
        wdt_cnt_reg <= '0;
      end else begin
        wdt_cnt_reg <= wdt_cnt_next;
      end
    end
  end

  // Arming: only the asynchronous power-on reset disarms.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdt_en_reg <= 1'b0;
    end else if (!power_on_flag_reg) begin
      wdt_en_reg <= 1'b1;
    end
  end

  // Status flags; software may clear them by writing zero but never set them.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      power_on_flag_reg <= SWC_SCR_RESET[SWC_SCR_POWER_ON_FLAG];
      watchdog_reset_flag_reg <= SWC_SCR_RESET[SWC_SCR_WATCHDOG_RESET_FLAG];
    end else begin
      if (wr_scr && !io_req.wdata[SWC_SCR_POWER_ON_FLAG]) begin
        power_on_flag_reg <= 1'b0;
      end
      if (wdr_now) begin
        watchdog_reset_flag_reg <= 1'b1;
      end else if (wr_scr && !io_req.wdata[SWC_SCR_WATCHDOG_RESET_FLAG]) begin
        watchdog_reset_flag_reg <= 1'b0;
      end
    end
  end

  // Sleep and stop control bits; the sequence clears sleep as it releases the CPU.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sleep_reg <= SWC_SCR_RESET[SWC_SCR_SLEEP];
      stop_reg  <= SWC_SCR_RESET[SWC_SCR_STOP];
    end else if (wdr_now) begin
      sleep_reg <= 1'b0;
      stop_reg  <= 1'b0;
    end else begin
      if (wr_scr) begin
        sleep_reg <= io_req.wdata[SWC_SCR_SLEEP];
        stop_reg  <= io_req.wdata[SWC_SCR_STOP];
      end else if (state_reg == SWC_SETTLE && state_next == SWC_RESUME) begin
        sleep_reg <= 1'b0;
      end
    end
  end

  // The sequence may not leave sleep while the stop bit is set.
  assign wake_ok = sy_fall[SY_LP] && sy_lvl[SY_WAKE] && !stop_reg;

  // Sleep sequencer transitions.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SWC_RUN: begin
        if (sleep_reg) begin
          state_next = SWC_HALT_REQ;
        end
      end
      SWC_HALT_REQ: begin
        if (sy_lvl[SY_ACK]) begin
          state_next = SWC_WAIT_NEG;
        end
      end
      SWC_WAIT_NEG: begin
        if (sy_fall[SY_CPU]) begin
          state_next = SWC_ASLEEP;
        end
      end
      SWC_ASLEEP: begin
        if (wake_ok) begin
          state_next = SWC_CAPTURED;
        end
      end
      SWC_CAPTURED: begin
        if (sy_rise[SY_LP]) begin
          state_next = SWC_POWER_UP;
        end
      end
      SWC_POWER_UP: begin
        if (sy_rise[SY_LP]) begin
          state_next = SWC_SETTLE;
        end
      end
      SWC_SETTLE: begin
        if (sy_fall[SY_LP] && rec_cnt_reg == SWC_OSC_RECOVERY) begin
          state_next = SWC_RESUME;
        end
      end
      SWC_RESUME: begin
        if (!sy_lvl[SY_ACK]) begin
          state_next = SWC_RUN;
        end
      end
      default: begin
        state_next = SWC_RUN;
      end
    endcase
  end

  // State register; a watchdog reset aborts any sequence.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SWC_RUN;
    end else if (wdr_now) begin
      state_reg <= SWC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Power-down rises entering sleep and falls on the wake rising edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pd_reg <= 1'b0;
    end else if (wdr_now) begin
      pd_reg <= 1'b0;
    end else if (state_next == SWC_ASLEEP && state_reg == SWC_WAIT_NEG) begin
      pd_reg <= 1'b1;
    end else if (state_next == SWC_POWER_UP && state_reg == SWC_CAPTURED) begin
      pd_reg <= 1'b0;
    end
  end

  // Oscillator recovery counts low-power periods after power-down ends.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rec_cnt_reg   <= '0;
      osc_ready_reg <= 1'b1;
    end else if (wdr_now) begin
      rec_cnt_reg   <= '0;
      osc_ready_reg <= 1'b1;
    end else if (pd_reg) begin
      rec_cnt_reg   <= '0;
      osc_ready_reg <= 1'b0;
    end else if (!osc_ready_reg && sy_rise[SY_LP]) begin
      if (rec_cnt_reg == SWC_OSC_RECOVERY - 2'h1) begin
        osc_ready_reg <= 1'b1;
      end
      rec_cnt_reg <= rec_cnt_reg + 2'h1;
    end
  end

  // Precision comparator sampled once it has settled; monitor mode never resets.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      precision_reset_detector_sample_reg <= 1'b0;
    end else if (state_reg == SWC_POWER_UP && state_next == SWC_SETTLE) begin
      precision_reset_detector_sample_reg <= sy_lvl[SY_PRECISION_RESET_DETECTOR] && (trip_reg != SWC_TRIP_MONITOR);
    end else if (state_reg == SWC_RUN) begin
      precision_reset_detector_sample_reg <= sy_lvl[SY_PRECISION_RESET_DETECTOR] && (trip_reg != SWC_TRIP_MONITOR);
    end
  end

  // Trip configuration register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trip_reg <= SWC_TRIP_RESET;
    end else if (wdr_now) begin
      trip_reg <= SWC_TRIP_RESET;
    end else if (wr_trip) begin
      trip_reg <= io_req.wdata[SWC_TRIP_MSB:SWC_TRIP_LSB];
    end
  end

  // Interrupt entry is held after wake until one instruction retires.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      defer_reg <= 1'b0;
    end else if (wdr_now) begin
      defer_reg <= 1'b0;
    end else if (state_reg == SWC_SETTLE && state_next == SWC_RESUME) begin
      defer_reg <= 1'b1;
    end else if (state_reg == SWC_RUN && (sy_rise[SY_RET] || sy_fall[SY_RET])) begin
      defer_reg <= 1'b0;
    end
  end

  // Read data; the clear register is write-only and reads as zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= SWC_RDATA_NONE;
    end else if (io_req.rd) begin
      rdata_reg <= SWC_RDATA_NONE;
      if (io_req.addr == SWC_ADDR_SCR) begin
        rdata_reg[SWC_SCR_GIE]   <= gie;
        rdata_reg[SWC_SCR_WATCHDOG_RESET_FLAG]  <= watchdog_reset_flag_reg;
        rdata_reg[SWC_SCR_POWER_ON_FLAG]  <= power_on_flag_reg;
        rdata_reg[SWC_SCR_SLEEP] <= sleep_reg;
        rdata_reg[SWC_SCR_RSVD2] <= SWC_SCR_RESET[SWC_SCR_RSVD2];
        rdata_reg[SWC_SCR_STOP]  <= stop_reg;
      end else if (io_req.addr == SWC_ADDR_TRIP) begin
        rdata_reg[SWC_TRIP_MSB:SWC_TRIP_LSB] <= trip_reg;
      end
    end
  end

  // Halt request rises with the sleep write and stands, without a gap, until the release step.
  assign halt_request = sleep_set_wr || (state_reg == SWC_RUN ? sleep_reg : state_reg != SWC_RESUME);

  // Circuits switched off by power-down; the low-power domain stays on.
  assign power_ctl.flash_en   = !pd_reg;
  assign power_ctl.osc_en     = !pd_reg;
  assign power_ctl.filter_en  = !pd_reg;
  assign power_ctl.bandgap_en = !pd_reg;

  // Remaining outputs.
  assign power_down              = pd_reg;
  assign osc_ready               = osc_ready_reg;
  assign watchdog_reset_event    = wdr_reg;
  assign sleep_timer_irq         = st_irq_reg;
  assign isr_defer               = defer_reg;
  assign cpu_stop                = stop_reg;
  assign reset_trip_level        = trip_reg;
  assign precision_reset_request = precision_reset_detector_sample_reg;
  assign io_rdata                = rdata_reg;

endmodule // swc_sleep_wake_watchdog_control

// >>> core/swc_pkg.sv
// Shared constants, types and register map of the sleep, wake and watchdog control block.
package swc_pkg;

  // Register addresses; bit 8 selects the second I/O bank.
  localparam logic [8:0] SWC_ADDR_WDT_CLEAR = 9'h0E3;
  localparam logic [8:0] SWC_ADDR_SCR       = 9'h0FF;
  localparam logic [8:0] SWC_ADDR_TRIP      = 9'h1E3;

  // Field positions in the system status and control register.
  localparam int SWC_SCR_GIE   = 7;
  localparam int SWC_SCR_WATCHDOG_RESET_FLAG  = 5;
  localparam int SWC_SCR_POWER_ON_FLAG  = 4;
  localparam int SWC_SCR_SLEEP = 3;
  localparam int SWC_SCR_RSVD2 = 2;
  localparam int SWC_SCR_STOP  = 0;

  // Field position of the trip level inside the trip configuration register.
  localparam int SWC_TRIP_LSB = 4;
  localparam int SWC_TRIP_MSB = 5;

  // Reset values.
  localparam logic [7:0] SWC_SCR_RESET  = 8'h14;
  localparam logic [1:0] SWC_TRIP_RESET = 2'h0;
  localparam logic [7:0] SWC_RDATA_NONE = 8'h00;

  // Trip level encodings.
  localparam logic [1:0] SWC_TRIP_2V7      = 2'h0;
  localparam logic [1:0] SWC_TRIP_3V0      = 2'h1;
  localparam logic [1:0] SWC_TRIP_RESERVED = 2'h2;
  localparam logic [1:0] SWC_TRIP_MONITOR  = 2'h3;

  // Watchdog clear data that also clears the sleep timer, and counts.
  localparam logic [7:0] SWC_CLEAR_BOTH   = 8'h38;
  localparam logic [1:0] SWC_WDT_LIMIT    = 2'h3;
  localparam logic [1:0] SWC_OSC_RECOVERY = 2'h3;

  // Sleep timer terminal counts in low-power clock periods, one per interval select.
  localparam logic [3:0][14:0] SWC_SLEEP_TERM = {15'h7FFF, 15'h0FFF, 15'h01FF, 15'h003F};

  // Sleep sequencer states.
  typedef enum logic [2:0] {
    SWC_RUN      = 3'b000,
    SWC_HALT_REQ = 3'b001,
    SWC_WAIT_NEG = 3'b010,
    SWC_ASLEEP   = 3'b011,
    SWC_CAPTURED = 3'b100,
    SWC_POWER_UP = 3'b101,
    SWC_SETTLE   = 3'b110,
    SWC_RESUME   = 3'b111
  } swc_state_type;

  // Register access from the CPU I/O bus.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } swc_io_req_type;

  // Enables of the circuits that power-down switches off.
  typedef struct packed {
    logic flash_en;
    logic osc_en;
    logic filter_en;
    logic bandgap_en;
  } swc_power_ctl_type;

endpackage

// >>> core/swc_sync.sv
// Three-stage input synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ns
module swc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // System clock.
  input  wire logic         nrst,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] din,   // Asynchronous inputs.
  output logic      [W-1:0] level, // Filtered level.
  output logic      [W-1:0] rise,  // One-cycle pulse on a rising change.
  output logic      [W-1:0] fall   // One-cycle pulse on a falling change.
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;

  // Shift chain; only the second stage reads the first.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once the second and third stages agree.
  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        level_next[i] = s3_reg[i];
      end
    end
  end

  // Filtered level register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_reg <= '0;
    end else begin
      level_reg <= level_next;
    end
  end

  // Edge pulses appear one cycle before the new level.
  assign level = level_reg;
  assign rise  = level_next & ~level_reg;
  assign fall  = ~level_next & level_reg;

endmodule // swc_sync

// >>> testbench/swc_checker_sva.sv
// Concurrent checks on the ports of the sleep, wake and watchdog control block.
`timescale 1ns/1ns
module swc_checker
  import swc_pkg::*;
(
  input wire logic                       clk,                     // Clock.
  input wire logic                       nrst,                    // Reset.
  input wire swc_pkg::swc_io_req_type    io_req,                  // Bus request.
  input wire logic                 [7:0] io_rdata,                // Read data.
  input wire logic                       lp_clk_in,               // Low-power clock.
  input wire logic                       processor_clock,         // CPU clock.
  input wire logic                       halt_acknowledge,        // Halt acknowledge.
  input wire logic                 [7:0] irq_pending,             // Pending sources.
  input wire logic                 [7:0] irq_mask,                // Mask.
  input wire logic                       gie,                     // Global enable.
  input wire logic                       instr_retired,           // Retire toggle.
  input wire logic                       precision_reset_detector_comparator,         // Comparator.
  input wire logic                 [1:0] sleep_interval_sel,      // Period select.
  input wire logic                       halt_request,            // Halt request.
  input wire logic                       power_down,              // Power-down.
  input wire swc_pkg::swc_power_ctl_type power_ctl,               // Enables.
  input wire logic                       osc_ready,               // Oscillator usable.
  input wire logic                       watchdog_reset_event,    // Watchdog reset.
  input wire logic                       sleep_timer_irq,         // Timer interrupt.
  input wire logic                       isr_defer,               // Interrupt hold.
  input wire logic                       cpu_stop,                // Stop bit.
  input wire logic                 [1:0] reset_trip_level,        // Trip level.
  input wire logic                       precision_reset_request  // Comparator reset.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Decoded register writes.
  logic clr_wr;
  logic trip_wr;
  logic sleep_wr;
  assign clr_wr   = io_req.wr && io_req.addr == SWC_ADDR_WDT_CLEAR;
  assign trip_wr  = io_req.wr && io_req.addr == SWC_ADDR_TRIP;
  assign sleep_wr = io_req.wr && io_req.addr == SWC_ADDR_SCR && io_req.wdata[SWC_SCR_SLEEP];
  // The halt is released by the wake sequence, not by a watchdog abort.
  sequence s_halt_drop;
    !watchdog_reset_event ##1 $fell(halt_request) && !watchdog_reset_event;
  endsequence
  property p_sleep_req; sleep_wr |-> halt_request; endproperty
  property p_pd_ack; $rose(power_down) |-> halt_request && halt_acknowledge; endproperty
  property p_pd_off; power_ctl == 4'({4{~power_down}}); endproperty
  property p_no_wake; power_down && !(|(irq_pending & irq_mask)) && !watchdog_reset_event |=> power_down; endproperty
  property p_irq_pulse; sleep_timer_irq |=> !sleep_timer_irq; endproperty
  property p_wdr_cause; watchdog_reset_event |-> sleep_timer_irq; endproperty
  property p_clr; clr_wr |-> ##2 !watchdog_reset_event; endproperty
  property p_trip; trip_wr |=> reset_trip_level == $past(io_req.wdata[5:4]); endproperty
  property p_pd_drop; $fell(power_down) |-> halt_request && !osc_ready; endproperty
  property p_resume; s_halt_drop |-> osc_ready && isr_defer; endproperty
  a_sleep_req: assert property (p_sleep_req) else $error("Sleep write without halt request.");
  a_pd_ack: assert property (p_pd_ack) else $error("Power-down before acknowledge.");
  a_pd_off: assert property (p_pd_off) else $error("Enables disagree with power-down.");
  a_no_wake: assert property (p_no_wake) else $error("Woke without unmasked interrupt.");
  a_irq_pulse: assert property (p_irq_pulse) else $error("Timer interrupt longer than one cycle.");
  a_wdr_cause: assert property (p_wdr_cause) else $error("Watchdog reset without overflow.");
  a_clr: assert property (p_clr) else $error("Watchdog reset after clear.");
  a_trip: assert property (p_trip) else $error("Trip level not written.");
  a_pd_drop: assert property (p_pd_drop) else $error("Power-up order wrong.");
  a_resume: assert property (p_resume) else $error("Halt released too early.");
endmodule // swc_checker

// >>> testbench/swc_cpu_model.sv
// Behavioural CPU core that answers halt requests and retires instructions.
`timescale 1ns/1ns
module swc_cpu_model (
  input  wire logic power_down,       // Stops the CPU clock while asleep.
  input  wire logic halt_request,     // Halt request from the sleep logic.
  output logic      processor_clock,  // CPU clock.
  output logic      halt_acknowledge, // Halt acknowledge.
  output logic      instr_retired     // Toggles once per retired instruction.
);
  // The CPU clock stands low while its oscillator is powered down.
  initial begin
    processor_clock  = 1'b0;
    halt_acknowledge = 1'b0;
    instr_retired    = 1'b0;
    forever begin
      #20;
      processor_clock = power_down ? 1'b0 : ~processor_clock;
    end
  end
  // Acknowledge follows the request at a rising edge; instructions retire only while running.
  always @(posedge processor_clock) begin
    halt_acknowledge <= halt_request;
    if (!halt_acknowledge && !halt_request) instr_retired <= ~instr_retired;
  end
endmodule // swc_cpu_model

// >>> testbench/tb_swc_sleep_wake_watchdog_control.sv
// Self-checking testbench of the sleep, wake and watchdog control block.
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_swc_sleep_wake_watchdog_control;
  import swc_pkg::*;
  logic clk, nrst, lp_clk_in, processor_clock, halt_acknowledge, gie, instr_retired, precision_reset_detector_comparator;
  logic halt_request, power_down, osc_ready, watchdog_reset_event, sleep_timer_irq, isr_defer, cpu_stop;
  logic precision_reset_request;
  logic [7:0] io_rdata, irq_pending, irq_mask, d;
  logic [1:0] sleep_interval_sel, reset_trip_level;
  swc_io_req_type    io_req;
  swc_power_ctl_type power_ctl;
  int errors, check_count, wdr_cnt, n;

  swc_sleep_wake_watchdog_control i_swc_sleep_wake_watchdog_control (.*);
  swc_cpu_model i_swc_cpu_model (.power_down(power_down), .halt_request(halt_request),
    .processor_clock(processor_clock), .halt_acknowledge(halt_acknowledge), .instr_retired(instr_retired));

  // System clock at 4 ns and a shortened low-power clock of 40 cycles.
  initial begin clk = 0; forever #2 clk = ~clk; end
  initial begin lp_clk_in = 0; #1; forever #80 lp_clk_in = ~lp_clk_in; end
  always @(posedge clk) if (watchdog_reset_event === 1'b1) wdr_cnt <= wdr_cnt + 1;

  task report_and_stop;
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One-cycle register bus accesses.
  task wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge clk) io_req <= '{1'b1, 1'b0, a, v};
    @(posedge clk) io_req <= '0;
    #1;
  endtask
  task rd(input logic [8:0] a);
    @(posedge clk) io_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) io_req <= '0;
    @(posedge clk) #1 d = io_rdata;
  endtask
  // Counts cycles up to the next sleep timer interrupt.
  task irq_wait;
    n = 0;
    do begin @(posedge clk); #1 n++; end while (sleep_timer_irq !== 1'b1 && n < 9000);
    if (sleep_timer_irq !== 1'b1) errors++;
  endtask
  task t_reset;
    rd(SWC_ADDR_SCR); `CHK(d, SWC_SCR_RESET)
    rd(SWC_ADDR_WDT_CLEAR); `CHK(d, SWC_RDATA_NONE)
    rd(9'h0E4); `CHK(d, SWC_RDATA_NONE)
    `CHK(power_ctl, 4'hF)
  endtask
  task t_trip;
    precision_reset_detector_comparator <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(SWC_ADDR_TRIP, {2'h0, 2'(i), 4'h0});
      `CHK(reset_trip_level, 2'(i))
      wr(SWC_ADDR_WDT_CLEAR, 8'h00);
      rd(SWC_ADDR_TRIP); `CHK(d[5:4], 2'(i))
      repeat (10) @(posedge clk);
      `CHK(precision_reset_request, 1'(i != 3))
    end
    precision_reset_detector_comparator <= 1'b0;
    wr(SWC_ADDR_TRIP, 8'h00);
  endtask
  task t_timer;
    irq_wait;
    irq_wait; `CHK(n, 2560)
    repeat (1000) @(posedge clk);
    wr(SWC_ADDR_WDT_CLEAR, 8'h00);
    irq_wait; `CHK(n, 1558)
    repeat (1000) @(posedge clk);
    wr(SWC_ADDR_WDT_CLEAR, SWC_CLEAR_BOTH);
    irq_wait; `CHK(n > 2500 && n < 2620, 1'b1)
  endtask
  task t_sleep;
    @(posedge clk) io_req <= '{1'b1, 1'b0, SWC_ADDR_SCR, 8'h18};
    #1 `CHK(halt_request, 1'b1)
    @(posedge clk) io_req <= '0;
    repeat (200) if (power_down !== 1'b1) @(posedge clk);
    `CHK(power_down, 1'b1)
    `CHK(power_ctl, 4'h0)
    irq_pending <= 8'h01;
    irq_mask    <= 8'h02;
    repeat (400) @(posedge clk);
    `CHK(power_down, 1'b1)
    irq_mask <= 8'h03;
    repeat (400) if (power_down !== 1'b0) @(posedge clk);
    #1 `CHK(power_down, 1'b0)
    `CHK(osc_ready, 1'b0)
    n = 0;
    while (halt_request !== 1'b0 && n < 400) begin @(posedge clk); #1 n++; end
    `CHK(n > 130 && n < 150, 1'b1)
    `CHK(isr_defer, 1'b1)
    repeat (200) if (isr_defer !== 1'b0) @(posedge clk);
    `CHK(isr_defer, 1'b0)
    irq_pending <= 8'h00;
    gie <= 1'b1;
    rd(SWC_ADDR_SCR); `CHK(d, 8'h94)
  endtask
  task t_watchdog;
    repeat (4) irq_wait;
    `CHK(wdr_cnt, 0)
    wr(SWC_ADDR_SCR, 8'h00);
    rd(SWC_ADDR_SCR); `CHK(d, 8'h84)
    repeat (4) begin irq_wait; wr(SWC_ADDR_WDT_CLEAR, 8'h5A); end
    `CHK(wdr_cnt, 0)
    repeat (3) irq_wait;
    `CHK(watchdog_reset_event, 1'b1)
    rd(SWC_ADDR_SCR); `CHK(d, 8'hA4)
    wr(SWC_ADDR_SCR, 8'h11);
    `CHK(cpu_stop, 1'b1)
    rd(SWC_ADDR_SCR); `CHK(d, 8'h85)
    repeat (3) irq_wait;
    `CHK(watchdog_reset_event, 1'b1)
    `CHK(cpu_stop, 1'b0)
    @(posedge clk) nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) irq_wait;
    `CHK(wdr_cnt, 2)
  endtask

  initial begin
    nrst = 0; io_req = '0; irq_pending = 0; irq_mask = 0; gie = 0;
    precision_reset_detector_comparator = 0; sleep_interval_sel = 0; errors = 0; check_count = 0; wdr_cnt = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_trip;
    t_timer;
    t_sleep;
    t_watchdog;
    report_and_stop;
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #300000;
    errors++;
    report_and_stop;
  end
endmodule // tb_swc_sleep_wake_watchdog_control

bind swc_sleep_wake_watchdog_control swc_checker i_swc_checker (.*);
